/* ess_encoder_source_select.sv */
// encoder source select: picks the encoder feeding the count and the home timing pulse
// assumes an avalon-mm master and an outside nonvolatile store reporting the saved selector
`timescale 1ns/1ns
module ess_encoder_source_select #(
	parameter logic [1:0] FACTORY_SELECT = ess_pkg::ESS_FACTORY_SELECT,
	parameter int         CW             = ess_pkg::ESS_COUNT_WIDTH
) (
	input  wire logic          mclk,
	input  wire logic          rst_n,
	input  wire logic [4:0]    avs_address,
	input  wire logic          avs_read,
	input  wire logic          avs_write,
	input  wire logic [31:0]   avs_writedata,
	input  wire logic [3:0]    avs_byteenable,
	output logic      [31:0]   avs_readdata,
	output logic               avs_waitrequest,
	input  wire logic          seqAccess,
	input  wire logic          savedValid,
	input  wire logic [1:0]    savedSelect,
	output logic               nvSaveStrobe,
	output logic      [1:0]    nvSaveValue,
	input  wire logic          driverPhaseA,
	input  wire logic          driverPhaseB,
	input  wire logic          externalPhaseA,
	input  wire logic          externalPhaseB,
	input  wire logic          driverTimingDiff,
	input  wire logic          externalZeroPulse,
	input  wire logic          timingSingleEnded,
	output logic               timingOut,
	output logic      [CW-1:0] encoderCount,
	output logic      [CW-1:0] feedbackPosition
);
	import ess_pkg::*;

	typedef struct packed {
		ess_bus_e      busState;
		logic          waitReq;
		logic [31:0]   rdData;
		logic          loaded;
		logic [1:0]    staged;
		logic [1:0]    active;
		logic          sourceSingle;
		logic [15:0]   scale;
		logic          saveStrobe;
		logic [1:0]    saveValue;
		logic          presetLoad;
		logic [CW-1:0] presetValue;
		logic          timingOut;
	} ess_top_s;

	ess_top_s s;
	ess_top_s next_s;
	logic     encA;
	logic     encB;

	function automatic logic [31:0] essMerge(input logic [31:0] old, input logic [31:0] wr,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wr[8*i +: 8];
			end
		end
		return r;
	endfunction

	// only the active selector steers the phase inputs
	assign encA = (s.active == ESS_SEL_EXTERNAL) ? externalPhaseA : driverPhaseA;
	assign encB = (s.active == ESS_SEL_EXTERNAL) ? externalPhaseB : driverPhaseB;

	always_comb begin
		logic [31:0] rd;
		rd = 32'h0000_0000;
		next_s = s;
		next_s.saveStrobe = 1'b0;
		next_s.presetLoad = 1'b0;

		// caught one cycle after release, since reset may only load constants
		if (!s.loaded) begin
			next_s.loaded = 1'b1;
			if (savedValid && savedSelect != ESS_SEL_ILLEGAL) begin
				next_s.active = savedSelect;
				next_s.staged = savedSelect;
			end else begin
				next_s.active = FACTORY_SELECT;
				next_s.staged = FACTORY_SELECT;
			end
		end

		if (s.sourceSingle == ESS_SRC_SINGLE) begin
			next_s.timingOut = timingSingleEnded;
		end else begin
			case (s.active)
				ESS_SEL_DRIVER:   next_s.timingOut = driverTimingDiff;
				ESS_SEL_EXTERNAL: next_s.timingOut = externalZeroPulse;
				default:          next_s.timingOut = 1'b0;
			endcase
		end

		case (avs_address)
			ESS_OFF_SELECT:     rd = {30'h0, s.staged};
			ESS_OFF_ACTIVE:     rd = {30'h0, s.active};
			ESS_OFF_TIMING_SRC: rd = {31'h0, s.sourceSingle};
			ESS_OFF_COUNT:      rd = 32'(encoderCount);
			ESS_OFF_FEEDBACK:   rd = 32'(feedbackPosition);
			ESS_OFF_SCALE:      rd = {16'h0, s.scale};
			default:            rd = 32'h0000_0000;
		endcase

		case (s.busState)
			ESS_BUS_IDLE: begin
				next_s.waitReq = 1'b1;
				if (avs_read) begin
					next_s.rdData = rd;
					next_s.waitReq = 1'b0;
					next_s.busState = ESS_BUS_ACK;
				end else if (avs_write) begin
					next_s.waitReq = 1'b0;
					next_s.busState = ESS_BUS_ACK;
				end
			end
			ESS_BUS_ACK: begin
				// write commits at the edge that sees waitrequest low
				next_s.waitReq = 1'b1;
				next_s.busState = ESS_BUS_IDLE;
				if (avs_write) begin
					case (avs_address)
						ESS_OFF_SELECT: begin
							// staged only; active takes it at the next reset only after a save, via savedSelect
							if (!seqAccess && avs_byteenable[0]
									&& avs_writedata[1:0] != ESS_SEL_ILLEGAL) begin
								next_s.staged = avs_writedata[1:0];
							end
						end
						ESS_OFF_TIMING_SRC: begin
							if (avs_byteenable[0]) begin
								next_s.sourceSingle = avs_writedata[0];
							end
						end
						ESS_OFF_SAVE: begin
							if (avs_byteenable[0] && avs_writedata[0]) begin
								next_s.saveStrobe = 1'b1;
								next_s.saveValue = s.staged;
							end
						end
						ESS_OFF_COUNT: begin
							if (s.active != ESS_SEL_NONE) begin
								next_s.presetLoad = 1'b1;
								next_s.presetValue = CW'(essMerge(32'(encoderCount),
									avs_writedata, avs_byteenable));
							end
						end
						ESS_OFF_SCALE: begin
							next_s.scale = 16'(essMerge({16'h0, s.scale}, avs_writedata,
								avs_byteenable));
						end
						default: begin
						end
					endcase
				end
			end
			default: begin
				next_s.waitReq = 1'b1;
				next_s.busState = ESS_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= '0;
			s.busState <= ESS_BUS_IDLE;
			s.waitReq <= 1'b1;
			s.scale <= ESS_SCALE_RESET;
		end else begin
			s <= next_s;
		end
	end

	ess_quad_decoder #(
		.CW (CW)
	) u_decoder (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.enable    (s.active != ESS_SEL_NONE),
		.phaseA    (encA),
		.phaseB    (encB),
		.load      (s.presetLoad),
		.loadValue (s.presetValue),
		.count     (encoderCount)
	);

	ess_position_scaler #(
		.CW    (CW),
		.SHIFT (ESS_SCALE_SHIFT)
	) u_scaler (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.count    (encoderCount),
		.scale    (s.scale),
		.position (feedbackPosition)
	);

	assign avs_readdata    = s.rdData;
	assign avs_waitrequest = s.waitReq;
	assign nvSaveStrobe    = s.saveStrobe;
	assign nvSaveValue     = s.saveValue;
	assign timingOut       = s.timingOut;

	a_zero_count: assert property (@(posedge mclk) disable iff (!rst_n)
		s.active == ESS_SEL_NONE |=> encoderCount == '0)
		else $error("count not held at zero with no encoder");

	a_active_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
		s.loaded |=> $stable(s.active))
		else $error("active selector changed without reset");

	a_power_load: assert property (@(posedge mclk) disable iff (!rst_n)
		rst_n && !s.loaded |=> s.active == ($past(savedValid)
			&& $past(savedSelect) != ESS_SEL_ILLEGAL
			? $past(savedSelect) : FACTORY_SELECT))
		else $error("selector not loaded from saved or factory value");

	a_seq_write: assert property (@(posedge mclk) disable iff (!rst_n)
		s.busState == ESS_BUS_ACK && avs_write && seqAccess && s.loaded
		|=> $stable(s.staged))
		else $error("sequence write changed the selector");

	a_timing_single: assert property (@(posedge mclk) disable iff (!rst_n)
		s.sourceSingle == ESS_SRC_SINGLE |=> timingOut == $past(timingSingleEnded))
		else $error("timing not from single-ended input");

	a_timing_select: assert property (@(posedge mclk) disable iff (!rst_n)
		s.sourceSingle == ESS_SRC_DIFF |=> timingOut ==
			($past(s.active) == ESS_SEL_DRIVER ? $past(driverTimingDiff) :
			 $past(s.active) == ESS_SEL_EXTERNAL ? $past(externalZeroPulse) : 1'b0))
		else $error("timing source does not follow selector");

	a_bus_answer: assert property (@(posedge mclk) disable iff (!rst_n)
		s.busState == ESS_BUS_IDLE && (avs_read || avs_write)
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not exactly one cycle");

	a_save_value: assert property (@(posedge mclk) disable iff (!rst_n)
		nvSaveStrobe |-> nvSaveValue == $past(s.staged) && !$past(nvSaveStrobe))
		else $error("save does not carry the staged selector");

	a_save_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
		s.busState == ESS_BUS_ACK && avs_write && avs_address == ESS_OFF_SAVE
		&& avs_byteenable[0] && avs_writedata[0] |=> nvSaveStrobe)
		else $error("save write gave no save pulse");

	a_save_single: assert property (@(posedge mclk) disable iff (!rst_n)
		nvSaveStrobe |=> !nvSaveStrobe)
		else $error("save pulse longer than one cycle");

	a_preset_load: assert property (@(posedge mclk) disable iff (!rst_n)
		s.presetLoad |=> encoderCount == $past(s.presetValue))
		else $error("count preset not taken");

	// a preset must never sneak past the unused selector
	a_preset_refused: assert property (@(posedge mclk) disable iff (!rst_n)
		s.active == ESS_SEL_NONE |-> !s.presetLoad)
		else $error("preset issued with no encoder selected");

	a_active_read: assert property (@(posedge mclk) disable iff (!rst_n)
		s.busState == ESS_BUS_IDLE && avs_read && avs_address == ESS_OFF_ACTIVE
		|=> avs_readdata == {30'h0, $past(s.active)})
		else $error("active selector read back wrong");

	a_staged_read: assert property (@(posedge mclk) disable iff (!rst_n)
		s.busState == ESS_BUS_IDLE && avs_read && avs_address == ESS_OFF_SELECT
		|=> avs_readdata == {30'h0, $past(s.staged)})
		else $error("staged selector read back wrong");

	a_staged_write: assert property (@(posedge mclk) disable iff (!rst_n)
		s.busState == ESS_BUS_ACK && avs_write && !seqAccess
		&& avs_address == ESS_OFF_SELECT && avs_byteenable[0]
		&& avs_writedata[1:0] != ESS_SEL_ILLEGAL
		|=> s.staged == $past(avs_writedata[1:0]))
		else $error("host select write not staged");

	a_illegal_select: assert property (@(posedge mclk) disable iff (!rst_n)
		s.busState == ESS_BUS_ACK && avs_write && avs_address == ESS_OFF_SELECT
		&& (!avs_byteenable[0] || avs_writedata[1:0] == ESS_SEL_ILLEGAL)
		|=> $stable(s.staged))
		else $error("refused select write changed the selector");

	a_idle_wait: assert property (@(posedge mclk) disable iff (!rst_n)
		s.busState == ESS_BUS_IDLE |-> avs_waitrequest)
		else $error("waitrequest low outside the answer cycle");
endmodule

/* ess_pkg.sv */
// constants shared by the encoder source select block and its helpers
// assumes a 32-bit avalon-mm register bus with byte addresses
package ess_pkg;
	localparam logic [4:0]  ESS_OFF_SELECT      = 5'h00;
	localparam logic [4:0]  ESS_OFF_ACTIVE      = 5'h04;
	localparam logic [4:0]  ESS_OFF_TIMING_SRC  = 5'h08;
	localparam logic [4:0]  ESS_OFF_SAVE        = 5'h0C;
	localparam logic [4:0]  ESS_OFF_COUNT       = 5'h10;
	localparam logic [4:0]  ESS_OFF_FEEDBACK    = 5'h14;
	localparam logic [4:0]  ESS_OFF_SCALE       = 5'h18;

	localparam logic [1:0]  ESS_SEL_NONE        = 2'h0;
	localparam logic [1:0]  ESS_SEL_DRIVER      = 2'h1;
	localparam logic [1:0]  ESS_SEL_EXTERNAL    = 2'h2;
	localparam logic [1:0]  ESS_SEL_ILLEGAL     = 2'h3;
	localparam logic [1:0]  ESS_FACTORY_SELECT  = 2'h1;

	localparam logic        ESS_SRC_DIFF        = 1'h0;
	localparam logic        ESS_SRC_SINGLE      = 1'h1;

	localparam logic [15:0] ESS_SCALE_RESET     = 16'h0001;
	localparam int          ESS_SCALE_SHIFT     = 0;
	localparam int          ESS_COUNT_WIDTH     = 32;

	typedef enum logic {
		ESS_BUS_IDLE,
		ESS_BUS_ACK
	} ess_bus_e;
endpackage

/* ess_quad_decoder.sv */
// quadrature decoder keeping the encoder count
// assumes a and b already synchronous to mclk
`timescale 1ns/1ns
module ess_quad_decoder #(
	parameter int CW = ess_pkg::ESS_COUNT_WIDTH
) (
	input  wire logic          mclk,
	input  wire logic          rst_n,
	input  wire logic          enable,
	input  wire logic          phaseA,
	input  wire logic          phaseB,
	input  wire logic          load,
	input  wire logic [CW-1:0] loadValue,
	output logic      [CW-1:0] count
);
	import ess_pkg::*;

	typedef struct packed {
		logic          prevA;
		logic          prevB;
		logic          armed;
		logic [CW-1:0] count;
	} ess_dec_s;

	ess_dec_s s;
	ess_dec_s next_s;

	// +1 forward, -1 backward, 0 idle or a skipped (double) step
	function automatic logic [1:0] essStep(input logic [3:0] t);
		case (t)
			4'h1, 4'h7, 4'hE, 4'h8: essStep = 2'h1;
			4'h2, 4'hB, 4'hD, 4'h4: essStep = 2'h3;
			default:                essStep = 2'h0;
		endcase
	endfunction

	always_comb begin
		next_s = s;
		next_s.prevA = phaseA;
		next_s.prevB = phaseB;
		// first enabled cycle only primes prev: the phase mux may just have switched encoders
		next_s.armed = enable;
		if (!enable) begin
			next_s.count = '0;
		end else if (load) begin
			next_s.count = loadValue;
		end else if (s.armed && essStep({s.prevA, s.prevB, phaseA, phaseB}) == 2'h1) begin
			next_s.count = s.count + 1'b1;
		end else if (s.armed && essStep({s.prevA, s.prevB, phaseA, phaseB}) == 2'h3) begin
			next_s.count = s.count - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign count = s.count;

	a_count_up: assert property (@(posedge mclk) disable iff (!rst_n)
		enable && !load && s.armed && essStep({s.prevA, s.prevB, phaseA, phaseB}) == 2'h1
		|=> count == $past(count) + 1'b1)
		else $error("count missed a forward step");

	a_count_down: assert property (@(posedge mclk) disable iff (!rst_n)
		enable && !load && s.armed && essStep({s.prevA, s.prevB, phaseA, phaseB}) == 2'h3
		|=> count == $past(count) - 1'b1)
		else $error("count missed a backward step");
endmodule

/* ess_position_scaler.sv */
// scales the encoder count into user units
// assumes scale and count change slowly against the one-cycle latency
`timescale 1ns/1ns
module ess_position_scaler #(
	parameter int CW    = ess_pkg::ESS_COUNT_WIDTH,
	parameter int SHIFT = ess_pkg::ESS_SCALE_SHIFT
) (
	input  wire logic          mclk,
	input  wire logic          rst_n,
	input  wire logic [CW-1:0] count,
	input  wire logic [15:0]   scale,
	output logic      [CW-1:0] position
);
	import ess_pkg::*;

	typedef struct packed {
		logic [CW-1:0] position;
	} ess_scl_s;

	ess_scl_s s;
	ess_scl_s next_s;
	logic signed [CW+16:0] product;

	// the scale is unsigned, so a zero bit keeps it positive in the product
	assign product = $signed(count) * $signed({1'b0, scale});

	always_comb begin
		next_s = s;
		next_s.position = CW'(product >>> SHIFT);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign position = s.position;

	a_scaled_value: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(rst_n) |-> position == CW'($past(product) >>> SHIFT))
		else $error("feedback position does not follow scaled count");
endmodule

/* ess_encoder_model.sv */
// quadrature encoder model for the driver or the external encoder
// assumes step and dir change just after a rising mclk edge
`timescale 1ns/1ns
module ess_encoder_model (
	input  wire logic mclk,
	input  wire logic step,
	input  wire logic dir,
	output logic      phaseA,
	output logic      phaseB,
	output logic      zeroPulse
);
	logic [1:0] idx = 2'h0;
	// one gray step per edge, so the decoder never sees a double jump
	always @(posedge mclk) begin
		if (step) begin
			idx <= dir ? idx - 2'h1 : idx + 2'h1;
		end
	end
	assign phaseA    = idx[1];
	assign phaseB    = idx[1] ^ idx[0];
	assign zeroPulse = (idx == 2'h0);
endmodule

/* tb_encoder_source_select.sv */
// self-checking bench for the encoder source select block
// assumes two encoder models and an avalon-mm master made by this bench
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
	compares++; \
	if ((got) !== (ex)) begin \
		num_errors++; \
		$display("wrong value %s expected %h seen %h", nm, ex, got); \
	end \
end
module tb_encoder_source_select;
	import ess_pkg::*;
	logic        mclk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata, encoderCount, feedbackPosition;
	logic [3:0]  avs_byteenable = 4'hF;
	logic        avs_waitrequest, nvSaveStrobe, timingOut, seqAccess = 1'b0;
	logic        savedValid = 1'b0, dStep = 1'b0, eStep = 1'b0, dir = 1'b0;
	logic        drvTim = 1'b0, singleTim = 1'b0, dA, dB, dZ, eA, eB, eZ;
	logic [1:0]  savedSelect = 2'h0, nvSaveValue;
	int          num_errors = 0, compares = 0, seed, saves = 0, n;
	logic [15:0] sc;

	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		if (nvSaveStrobe === 1'b1) begin
			saves++;
		end
	end

	ess_encoder_model drv_inst (.mclk(mclk), .step(dStep), .dir(dir), .phaseA(dA),
		.phaseB(dB), .zeroPulse(dZ));
	ess_encoder_model ext_inst (.mclk(mclk), .step(eStep), .dir(dir), .phaseA(eA),
		.phaseB(eB), .zeroPulse(eZ));
	ess_encoder_source_select ess_encoder_source_select_inst (.mclk(mclk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.seqAccess(seqAccess), .savedValid(savedValid), .savedSelect(savedSelect),
		.nvSaveStrobe(nvSaveStrobe), .nvSaveValue(nvSaveValue), .driverPhaseA(dA),
		.driverPhaseB(dB), .externalPhaseA(eA), .externalPhaseB(eB),
		.driverTimingDiff(drvTim), .externalZeroPulse(eZ),
		.timingSingleEnded(singleTim), .timingOut(timingOut),
		.encoderCount(encoderCount), .feedbackPosition(feedbackPosition));

	function automatic logic [31:0] expFeed(input logic [31:0] c, input logic [15:0] s);
		return c * {16'h0, s};
	endfunction

	function automatic logic expTim(input logic src, input logic [1:0] encoder_source_select, input logic d,
			input logic sg, input logic z);
		if (src == ESS_SRC_SINGLE) begin
			return sg;
		end
		return (encoder_source_select == ESS_SEL_DRIVER) ? d : ((encoder_source_select == ESS_SEL_EXTERNAL) ? z : 1'b0);
	endfunction

	task automatic finish_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// held until waitrequest is seen low, then released with one idle edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int k;
		k = 0;
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge mclk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		if (k >= 50) begin
			num_errors++;
			finish_test();
		end
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic turn(input int steps, input logic d, input logic ext);
		for (int i = 0; i < steps; i++) begin
			dStep <= !ext;
			eStep <= ext;
			dir <= d;
			@(posedge mclk);
		end
		dStep <= 1'b0;
		eStep <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask

	task automatic do_reset(input logic v, input logic [1:0] s);
		savedValid <= v;
		savedSelect <= s;
		rst_n <= 1'b0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask

	task automatic timing(input logic src, input logic [1:0] encoder_source_select);
		logic d;
		logic s;
		bus(1'b1, ESS_OFF_TIMING_SRC, {31'h0, src});
		for (int i = 0; i < 6; i++) begin
			d = 1'($random(seed));
			s = 1'($random(seed));
			drvTim <= d;
			singleTim <= s;
			repeat (2) @(posedge mclk);
			`CHK("timing", expTim(src, encoder_source_select, d, s, eZ), timingOut)
		end
	endtask

	initial begin
		seed = 44042;
		do_reset(1'b0, 2'h0);
		bus(1'b0, ESS_OFF_ACTIVE, 32'h0);
		`CHK("active", ESS_FACTORY_SELECT, rdata[1:0])
		n = 1 + ($unsigned($random(seed)) % 20);
		turn(n, 1'b0, 1'b0);
		turn(3, 1'b0, 1'b1);
		bus(1'b0, ESS_OFF_COUNT, 32'h0);
		`CHK("count up", n, rdata)
		turn(n + 2, 1'b1, 1'b0);
		bus(1'b0, ESS_OFF_COUNT, 32'h0);
		`CHK("count down", 32'hFFFFFFFE, rdata)
		sc = 16'($random(seed));
		bus(1'b1, ESS_OFF_SCALE, {16'h0, sc});
		bus(1'b0, ESS_OFF_FEEDBACK, 32'h0);
		`CHK("feedback", expFeed(32'hFFFFFFFE, sc), rdata)
		`CHK("feedback port", expFeed(32'hFFFFFFFE, sc), feedbackPosition)
		timing(1'b0, ESS_SEL_DRIVER);
		timing(1'b1, ESS_SEL_DRIVER);
		bus(1'b0, 5'h1C, 32'h0);
		`CHK("unmapped", 32'h0, rdata)
		seqAccess <= 1'b1;
		bus(1'b1, ESS_OFF_SELECT, 32'h2);
		seqAccess <= 1'b0;
		bus(1'b0, ESS_OFF_SELECT, 32'h0);
		`CHK("seq write", ESS_SEL_DRIVER, rdata[1:0])
		bus(1'b1, ESS_OFF_SELECT, {30'h0, ESS_SEL_ILLEGAL});
		avs_byteenable <= 4'hE;
		bus(1'b1, ESS_OFF_SELECT, 32'h0);
		avs_byteenable <= 4'hF;
		bus(1'b0, ESS_OFF_SELECT, 32'h0);
		`CHK("refused select", ESS_SEL_DRIVER, rdata[1:0])
		bus(1'b1, ESS_OFF_SELECT, 32'h2);
		bus(1'b0, ESS_OFF_ACTIVE, 32'h0);
		`CHK("active unsaved", ESS_SEL_DRIVER, rdata[1:0])
		bus(1'b1, ESS_OFF_SAVE, 32'h1);
		`CHK("save value", ESS_SEL_EXTERNAL, nvSaveValue)
		@(posedge mclk);
		`CHK("save pulses", 1, saves)
		do_reset(1'b1, nvSaveValue);
		bus(1'b0, ESS_OFF_ACTIVE, 32'h0);
		`CHK("active saved", ESS_SEL_EXTERNAL, rdata[1:0])
		turn(n, 1'b0, 1'b1);
		turn(3, 1'b0, 1'b0);
		bus(1'b0, ESS_OFF_COUNT, 32'h0);
		`CHK("ext count", n, rdata)
		timing(1'b0, ESS_SEL_EXTERNAL);
		timing(1'b1, ESS_SEL_EXTERNAL);
		sc = 16'($random(seed));
		bus(1'b1, ESS_OFF_COUNT, {16'h0, sc});
		@(posedge mclk);
		bus(1'b0, ESS_OFF_FEEDBACK, 32'h0);
		`CHK("preset", expFeed({16'h0, sc}, ESS_SCALE_RESET), rdata)
		bus(1'b1, ESS_OFF_SELECT, 32'h0);
		bus(1'b1, ESS_OFF_SAVE, 32'h1);
		do_reset(1'b1, nvSaveValue);
		turn(5, 1'b0, 1'b0);
		turn(5, 1'b0, 1'b1);
		bus(1'b1, ESS_OFF_COUNT, 32'h55);
		bus(1'b0, ESS_OFF_FEEDBACK, 32'h0);
		`CHK("unused feedback", 32'h0, rdata)
		`CHK("unused count", 32'h0, encoderCount)
		`CHK("save pulses", 2, saves)
		timing(1'b0, ESS_SEL_NONE);
		timing(1'b1, ESS_SEL_NONE);
		finish_test();
	end
endmodule
